// ===== vsa_pkg.sv
// Shared constants and types for the video signature analyzer block.
// Assumes a single 250 MHz video clock and a synchronous active-high reset.
package vsa_pkg;

  // ------------------------------------------------------------
  // Command register layout
  // ------------------------------------------------------------
  localparam int unsigned CMD_W           = 16;
  localparam int unsigned CMD_SIG_EN_BIT  = 14;
  localparam int unsigned CMD_OPC_LSB     = 8;
  localparam int unsigned CMD_IDLE_BIT    = 0;
  localparam logic [4:0]  OPC_LOAD_ALL    = 5'h00;
  localparam logic [7:0]  REG_ID_SIG_DUMP = 8'h3C;
  localparam logic [7:0]  REG_ID_SIG_READ = 8'h3D;

  // ------------------------------------------------------------
  // Status and mask words
  // ------------------------------------------------------------
  localparam int unsigned STAT_W          = 16;
  localparam int unsigned STAT_RSVD_BIT   = 1;
  localparam int unsigned STAT_IDLE_BIT   = 0;
  localparam logic [15:0] STAT_RESET      = 16'h0000;
  localparam logic [15:0] MASK_RESET      = 16'hFFFF;

  // ------------------------------------------------------------
  // Signature register
  // ------------------------------------------------------------
  localparam int unsigned SIG_W           = 16;
  localparam logic [15:0] SIG_POLY        = 16'h1007;  // x^12 + x^2 + x + 1 taps
  localparam logic [15:0] SIG_RESET       = 16'h0000;
  localparam logic [7:0]  PIX_ALL_HIGH    = 8'hFF;
  localparam logic [7:0]  PIX_ALL_LOW     = 8'h00;

  // ------------------------------------------------------------
  // Test mode straps and modes
  // ------------------------------------------------------------
  localparam logic [2:0]  STRAP_RSVD0     = 3'h0;
  localparam logic [2:0]  STRAP_RSVD1     = 3'h1;
  localparam logic [2:0]  STRAP_TEST      = 3'h2;
  localparam logic [2:0]  STRAP_HIGH      = 3'h3;
  localparam logic [2:0]  STRAP_LOW       = 3'h4;
  localparam logic [2:0]  STRAP_FLOAT     = 3'h5;

  typedef enum logic [5:0] {
    MODE_NORMAL = 6'b00_0001,
    MODE_TEST   = 6'b00_0010,
    MODE_HIGH   = 6'b00_0100,
    MODE_LOW    = 6'b00_1000,
    MODE_FLOAT  = 6'b01_0000,
    MODE_RSVD   = 6'b10_0000
  } vsa_mode_t;

  typedef enum logic [1:0] {
    CMD_IDLE = 2'b01,
    CMD_BUSY = 2'b10
  } vsa_cmd_state_t;

  // Raster timing, same clock
  typedef struct packed {
    logic active;  // Active display time
    logic blank;   // Blanking, horizontal or vertical
    logic hsync;   // Horizontal sync, active high
    logic vsync;   // Vertical sync, active high
  } vsa_timing_t;

endpackage : vsa_pkg

// ===== vsa_sig_misr.sv
// Multiple-input signature register folding one pixel byte per clock.
// Assumes the caller supplies clear and enable on the same clock.
module vsa_sig_misr #(
  parameter int unsigned DATA_W = 8
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // Control
  input  wire logic              clear,
  input  wire logic              enable,
  input  wire logic [DATA_W-1:0] data,
  // Result
  output logic [vsa_pkg::SIG_W-1:0] sig_q
);

  // ------------------------------------------------------------
  // Elaboration check
  // ------------------------------------------------------------
  if (DATA_W < 1 || DATA_W > vsa_pkg::SIG_W) begin : g_bad_width
    $error("DATA_W out of range");
  end

  // ------------------------------------------------------------
  // Update function
  // ------------------------------------------------------------
  // Eight serial Galois steps, MSB of the byte first
  function automatic logic [vsa_pkg::SIG_W-1:0] fold(
    input logic [vsa_pkg::SIG_W-1:0] s,
    input logic [DATA_W-1:0]         d
  );
    logic [vsa_pkg::SIG_W-1:0] r;
    logic                      fb;
    r = s;
    for (int i = DATA_W - 1; i >= 0; i--) begin
      fb = r[vsa_pkg::SIG_W-1] ^ d[i];
      r  = {r[vsa_pkg::SIG_W-2:0], 1'b0};
      if (fb) begin
        r = r ^ vsa_pkg::SIG_POLY;  // see R19
      end
    end
    return r;
  endfunction : fold

  logic [vsa_pkg::SIG_W-1:0] sig_d;

  // Clear wins over an update so a frame starts from zero
  always_comb begin
    sig_d = sig_q;
    if (clear) begin
      sig_d = vsa_pkg::SIG_RESET;  // see R22
    end else if (enable) begin
      sig_d = fold(sig_q, data);  // see R22
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sig_q <= vsa_pkg::SIG_RESET;
    end else begin
      sig_q <= sig_d;
    end
  end

endmodule : vsa_sig_misr

// ===== vsa_display_test.sv
// Reset, strap test modes and video signature of the display processor.
// Assumes timing, command engine and dump path share the video clock.
//
// Overview of operation
// R1: Reset halts commands and abandons all fetches.
// R2: Reset drives video pins to default video.
// R3: Sync pins float until first load-all; force high and low drive them from the mode latch on.
// R4: Reset clears status, masks all, sets idle.
// R5: Straps held in reset, latched at release.
// R6: Strap code selects test, force or normal.
// R7: Codes 0,1 reserved; 2 test; 3-5 force; 11x normal.
// R8: Signature drive needs command bit 14 in test.
// R9: Other command bits work as normal in test.
// R10: Bit 14 in normal mode: reject, flag reserved.
// R11: Active display folds every pixel each clock.
// R12: Blanking shows low byte, high byte in hsync.
// R13: Signature spans whole frame, ready at retrace.
// R14: Signature clears on falling vertical sync.
// R15: Dump of id 3C returns signature as 3D.
// R16: Blanking shows default video, or signature in test.
// R17: Accumulator runs in every mode; here it is held in float mode.
// R18: Pin value equals value read back.
// R19: 16-bit LFSR, x^16+x^12+x^2+x+1.
// R20: Only bytes leaving the video pins accumulate.
// R21: Testers should check per-line signatures.
// R22: Parallel byte fold, zero after each clear.
module vsa_display_test #(
  parameter int unsigned PIX_W = 8
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  // Test straps, asynchronous pins
  input  wire logic                      rd_strap_n,
  input  wire logic                      wr_strap_n,
  input  wire logic                      memory_io_select,
  // Command write and dump, same clock
  input  wire logic                      cmd_wr,
  input  wire logic [vsa_pkg::CMD_W-1:0] cmd_wdata,
  input  wire logic                      cmd_done,
  input  wire logic                      dump_req,
  input  wire logic [7:0]                dump_id,
  // Status and mask access
  input  wire logic                      status_clr,
  input  wire logic                      mask_wr,
  input  wire logic [vsa_pkg::STAT_W-1:0] mask_wdata,
  // Raster and pixel stream
  input  wire vsa_pkg::vsa_timing_t      timing,
  input  wire logic [PIX_W-1:0]          pixel_in,
  input  wire logic [PIX_W-1:0]          default_video,
  // Command engine side
  output logic                           fetch_abort_q,
  output logic                           cmd_start_q,
  output logic [vsa_pkg::CMD_W-1:0]      display_command_register_q,
  output logic                           command_idle_flag_q,
  output logic [vsa_pkg::STAT_W-1:0]     display_status_word_q,
  output logic [vsa_pkg::STAT_W-1:0]     irq_mask_q,
  output logic                           dump_valid_q,
  output logic [vsa_pkg::SIG_W-1:0]      dump_data_q,
  output logic [5:0]                     test_mode_q,
  // Video and sync pins, enable low while driving
  output logic [PIX_W-1:0]               video_pixel_out_q,
  output logic                           video_oe_n_q,
  output logic                           hsync_out_q,
  output logic                           vsync_out_q,
  output logic                           retrace_gate_out_q,
  output logic                           sync_oe_n_q
);

  // ------------------------------------------------------------
  // Elaboration check
  // ------------------------------------------------------------
  if (PIX_W != 8) begin : g_bad_pix
    $error("PIX_W must be 8");
  end
  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  // Strap code {read, write, select} to mode
  function automatic vsa_pkg::vsa_mode_t decode_strap(input logic [2:0] code);
    vsa_pkg::vsa_mode_t m;
    m = vsa_pkg::MODE_NORMAL;
    if (code == vsa_pkg::STRAP_RSVD0 || code == vsa_pkg::STRAP_RSVD1) begin
      m = vsa_pkg::MODE_RSVD;  // see R7
    end else if (code == vsa_pkg::STRAP_TEST) begin
      m = vsa_pkg::MODE_TEST;  // see R7
    end else if (code == vsa_pkg::STRAP_HIGH) begin
      m = vsa_pkg::MODE_HIGH;  // see R7
    end else if (code == vsa_pkg::STRAP_LOW) begin
      m = vsa_pkg::MODE_LOW;  // see R7
    end else if (code == vsa_pkg::STRAP_FLOAT) begin
      m = vsa_pkg::MODE_FLOAT;  // see R7
    end
    return m;
  endfunction : decode_strap

  // ------------------------------------------------------------
  // Strap synchronisers
  // ------------------------------------------------------------
  // No reset: the pins keep flowing, so release sees the held straps
  logic [2:0] strap_s1_q;
  logic [2:0] strap_s2_q;
  logic [2:0] strap_s3_q;
  logic [2:0] strap_stable_q;
  logic [2:0] strap_stable_d;
  logic       rst_seen_q;
  // A change counts once the last two stages agree
  always_comb begin
    strap_stable_d = strap_stable_q;
    if (strap_s2_q == strap_s3_q) begin
      strap_stable_d = strap_s3_q;
    end
  end
  always_ff @(posedge clk) begin
    strap_s1_q     <= {rd_strap_n, wr_strap_n, memory_io_select};
    strap_s2_q     <= strap_s1_q;
    strap_s3_q     <= strap_s2_q;
    strap_stable_q <= strap_stable_d;
    rst_seen_q     <= sys_rst;
  end

  // ------------------------------------------------------------
  // Mode latch
  // ------------------------------------------------------------
  vsa_pkg::vsa_mode_t mode_q;
  vsa_pkg::vsa_mode_t mode_d;
  // Caught on the first edge after reset releases
  always_comb begin
    mode_d = mode_q;
    if (rst_seen_q) begin
      mode_d = decode_strap(strap_stable_q);  // see R5 see R6
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_q <= vsa_pkg::MODE_NORMAL;
    end else begin
      mode_q <= mode_d;
    end
  end

  // ------------------------------------------------------------
  // Command acceptance
  // ------------------------------------------------------------
  vsa_pkg::vsa_cmd_state_t     cst_q;
  vsa_pkg::vsa_cmd_state_t     cst_d;
  logic [vsa_pkg::CMD_W-1:0]   cmd_d;
  logic [vsa_pkg::STAT_W-1:0]  stat_d;
  logic [vsa_pkg::STAT_W-1:0]  mask_d;
  logic                        idle_d;
  logic                        start_d;
  logic                        sync_en_q;
  logic                        sync_en_d;
  logic                        illegal;
  logic                        is_load_all;
  assign illegal     = cmd_wdata[vsa_pkg::CMD_SIG_EN_BIT] && mode_q != vsa_pkg::MODE_TEST;
  assign is_load_all = cmd_wdata[vsa_pkg::CMD_OPC_LSB +: 5] == vsa_pkg::OPC_LOAD_ALL;

  // Writes are taken only when idle; a busy engine keeps its opcode
  always_comb begin
    cst_d     = cst_q;
    cmd_d     = display_command_register_q;
    stat_d    = display_status_word_q;
    mask_d    = irq_mask_q;
    idle_d    = command_idle_flag_q;
    start_d   = 1'b0;
    sync_en_d = sync_en_q;
    if (status_clr) begin
      stat_d[vsa_pkg::STAT_RSVD_BIT] = 1'b0;
    end
    if (mask_wr) begin
      mask_d = mask_wdata;
    end
    case (cst_q)
      vsa_pkg::CMD_IDLE: begin
        if (cmd_wr && illegal) begin
          stat_d[vsa_pkg::STAT_RSVD_BIT] = 1'b1;  // see R10
        end else if (cmd_wr) begin
          cmd_d   = cmd_wdata;  // see R9
          idle_d  = 1'b0;
          start_d = 1'b1;
          cst_d   = vsa_pkg::CMD_BUSY;
          sync_en_d = sync_en_q || is_load_all;  // see R3
        end
      end
      vsa_pkg::CMD_BUSY: begin
        if (cmd_done) begin
          idle_d = 1'b1;
          cst_d  = vsa_pkg::CMD_IDLE;
        end
      end
      default: begin
        cst_d = vsa_pkg::CMD_IDLE;
      end
    endcase
    cmd_d[vsa_pkg::CMD_IDLE_BIT]  = idle_d;
    stat_d[vsa_pkg::STAT_IDLE_BIT] = idle_d;
  end
  // Reset drops any command and fetch at once
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cst_q                      <= vsa_pkg::CMD_IDLE;  // see R1
      fetch_abort_q              <= 1'b1;  // see R1
      cmd_start_q                <= 1'b0;
      display_command_register_q <= 16'h0001;
      command_idle_flag_q        <= 1'b1;  // see R4
      display_status_word_q      <= vsa_pkg::STAT_RESET;  // see R4
      irq_mask_q                 <= vsa_pkg::MASK_RESET;  // see R4
      sync_en_q                  <= 1'b0;  // see R3
    end else begin
      cst_q                      <= cst_d;
      fetch_abort_q              <= 1'b0;
      cmd_start_q                <= start_d;
      display_command_register_q <= cmd_d;
      command_idle_flag_q        <= idle_d;
      display_status_word_q      <= stat_d;
      irq_mask_q                 <= mask_d;
      sync_en_q                  <= sync_en_d;
    end
  end

  // ------------------------------------------------------------
  // Signature accumulator
  // ------------------------------------------------------------
  logic [vsa_pkg::SIG_W-1:0] sig_q;
  logic                      vsync_prev_q;
  logic                      vsync_fall;
  logic                      pins_driven;
  logic [PIX_W-1:0]          vid_d;
  assign vsync_fall  = vsync_prev_q && !timing.vsync;  // see R14
  // A floating bus carries nothing out, so nothing is folded
  assign pins_driven = mode_q != vsa_pkg::MODE_FLOAT;
  // Runs in every mode except float and across all lines of a frame
  vsa_sig_misr #(
    .DATA_W (PIX_W)
  ) u_misr (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clear   (vsync_fall),  // see R14 see R13
    .enable  (timing.active && !timing.blank && pins_driven),  // see R11 see R17 see R20
    .data    (vid_d),  // see R20
    .sig_q   (sig_q)
  );

  // ------------------------------------------------------------
  // Video and sync pin drivers
  // ------------------------------------------------------------
  logic video_oe_n_d;
  logic hs_d;
  logic vs_d;
  logic rg_d;
  logic sync_oe_n_d;
  // Test mode only replaces blanking, and only with bit 14 set
  always_comb begin
    vid_d        = pixel_in;
    video_oe_n_d = 1'b0;
    hs_d         = timing.hsync;
    vs_d         = timing.vsync;
    rg_d         = timing.blank;
    sync_oe_n_d  = !sync_en_q;  // see R3
    if (timing.blank) begin
      vid_d = default_video;  // see R16
      if (mode_q == vsa_pkg::MODE_TEST
          && display_command_register_q[vsa_pkg::CMD_SIG_EN_BIT]) begin  // see R8
        vid_d = timing.hsync ? sig_q[15:8] : sig_q[7:0];  // see R12 see R18
      end
    end
    case (mode_q)
      vsa_pkg::MODE_HIGH: begin
        vid_d              = vsa_pkg::PIX_ALL_HIGH;  // see R6
        {hs_d, vs_d, rg_d} = 3'b111;
        sync_oe_n_d        = 1'b0;
      end
      vsa_pkg::MODE_LOW: begin
        vid_d              = vsa_pkg::PIX_ALL_LOW;  // see R6
        {hs_d, vs_d, rg_d} = 3'b000;
        sync_oe_n_d        = 1'b0;
      end
      vsa_pkg::MODE_FLOAT: begin
        video_oe_n_d = 1'b1;
        sync_oe_n_d  = 1'b1;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      video_pixel_out_q  <= default_video;  // see R2
      video_oe_n_q       <= 1'b0;
      hsync_out_q        <= 1'b0;
      vsync_out_q        <= 1'b0;
      retrace_gate_out_q <= 1'b0;
      sync_oe_n_q        <= 1'b1;  // see R3
      vsync_prev_q       <= 1'b0;
    end else begin
      video_pixel_out_q  <= vid_d;
      video_oe_n_q       <= video_oe_n_d;
      hsync_out_q        <= hs_d;
      vsync_out_q        <= vs_d;
      retrace_gate_out_q <= rg_d;
      sync_oe_n_q        <= sync_oe_n_d;
      vsync_prev_q       <= timing.vsync;
    end
  end

  // ------------------------------------------------------------
  // Register dump and mode report
  // ------------------------------------------------------------
  logic                      dump_valid_d;
  logic [vsa_pkg::SIG_W-1:0] dump_data_d;
  // Same register the pins show during blanking
  always_comb begin
    dump_valid_d = dump_req;
    dump_data_d  = dump_data_q;
    if (dump_req && dump_id == vsa_pkg::REG_ID_SIG_DUMP) begin
      dump_data_d = sig_q;  // see R15 see R18
    end else if (dump_req) begin
      dump_data_d = 16'h0000;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dump_valid_q <= 1'b0;
      dump_data_q  <= 16'h0000;
      test_mode_q  <= vsa_pkg::MODE_NORMAL;
    end else begin
      dump_valid_q <= dump_valid_d;
      dump_data_q  <= dump_data_d;
      test_mode_q  <= mode_q;
    end
  end

endmodule : vsa_display_test

// ===== vsa_palette_model.sv
// Palette model: the level seen on the video pins.
// Assumes oe_n low drives; no pull on the pins.
module vsa_palette_model (
  // Clock
  input  wire logic       clk,
  // Video pins from the block
  input  wire logic [7:0] pix_drv,
  input  wire logic       pix_oe_n,
  // Level seen by the palette, checked line by line
  output logic [7:0]      pix_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] last_q = 8'h00;
  // Released pins toggle so a stale byte never passes as driven
  always_comb pix_seen = pix_oe_n ? ~last_q : pix_drv;
  // Level kept for released cycles
  always_ff @(posedge clk) last_q <= pix_seen;
endmodule : vsa_palette_model

// ===== vsa_display_test_asserts.sv
// Checker for the display test block, watching only its top ports.
// Assumes one clock and a synchronous active-high reset.
module vsa_display_test_asserts #(
  parameter int unsigned PIX_W = 8
) (
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 sys_rst,
  // Requests
  input wire logic                 cmd_wr,
  input wire logic [15:0]          cmd_wdata,
  input wire logic                 dump_req,
  input wire logic [7:0]           dump_id,
  input wire vsa_pkg::vsa_timing_t timing,
  input wire logic [PIX_W-1:0]     pixel_in,
  input wire logic [PIX_W-1:0]     default_video,
  // Answers
  input wire logic                 fetch_abort_q,
  input wire logic                 cmd_start_q,
  input wire logic                 command_idle_flag_q,
  input wire logic [15:0]          display_status_word_q,
  input wire logic [15:0]          irq_mask_q,
  input wire logic                 dump_valid_q,
  input wire logic [15:0]          dump_data_q,
  input wire logic [5:0]           test_mode_q,
  input wire logic [PIX_W-1:0]     video_pixel_out_q,
  input wire logic                 video_oe_n_q,
  input wire logic                 sync_oe_n_q
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // Settle counter
  // ----------------------------------------
  logic [1:0] settle_q;
  logic [1:0] settle_d;
  // Mode settles two edges after release
  always_comb begin
    settle_d = settle_q;
    if (sys_rst) settle_d = 2'h0;
    else if (settle_q != 2'h3) settle_d = settle_q + 2'h1;
  end
  always_ff @(posedge clk) settle_q <= settle_d;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  reset_state_a: assert property (disable iff (1'b0) sys_rst |=>
    fetch_abort_q && sync_oe_n_q && command_idle_flag_q && irq_mask_q == 16'hFFFF
    && !video_oe_n_q && video_pixel_out_q == $past(default_video))
    else $error("reset state wrong");
  status_clear_a: assert property (disable iff (1'b0) sys_rst |=>
    display_status_word_q[15:1] == 15'h0000) else $error("status not cleared");
  illegal_cmd_a: assert property (cmd_wr && command_idle_flag_q && cmd_wdata[14]
    && test_mode_q != vsa_pkg::MODE_TEST |=> !cmd_start_q && display_status_word_q[1])
    else $error("illegal command run");
  legal_start_a: assert property (cmd_wr && command_idle_flag_q
    && (!cmd_wdata[14] || test_mode_q == vsa_pkg::MODE_TEST) |=> cmd_start_q ##1 !cmd_start_q)
    else $error("legal command not started");
  sync_hold_a: assert property (settle_q == 2'h3 && $fell(sync_oe_n_q)
    |-> $past(cmd_wr) || $past(cmd_wr, 2)) else $error("sync driven early");
  blank_default_a: assert property (settle_q == 2'h3 && timing.blank
    && test_mode_q == vsa_pkg::MODE_NORMAL |=> video_pixel_out_q == $past(default_video))
    else $error("blank not default");
  active_pixel_a: assert property (settle_q == 2'h3 && timing.active
    && !timing.blank && test_mode_q != vsa_pkg::MODE_HIGH && test_mode_q != vsa_pkg::MODE_LOW
    && test_mode_q != vsa_pkg::MODE_FLOAT |=> video_pixel_out_q == $past(pixel_in))
    else $error("pixel not passed");
  force_high_a: assert property (settle_q == 2'h3 && test_mode_q == vsa_pkg::MODE_HIGH
    |-> video_pixel_out_q == '1 && !video_oe_n_q) else $error("not forced high");
  force_low_a: assert property (settle_q == 2'h3 && test_mode_q == vsa_pkg::MODE_LOW
    |-> video_pixel_out_q == '0 && !video_oe_n_q) else $error("not forced low");
  float_all_a: assert property (settle_q == 2'h3 && test_mode_q == vsa_pkg::MODE_FLOAT
    |-> video_oe_n_q && sync_oe_n_q) else $error("pins not floating");
  dump_other_a: assert property (dump_req && dump_id != 8'h3C
    |=> dump_valid_q && dump_data_q == 16'h0000) else $error("other id not zero");
endmodule : vsa_display_test_asserts

bind vsa_display_test vsa_display_test_asserts #(.PIX_W(PIX_W)) u_asserts (
  .clk(clk), .sys_rst(sys_rst), .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata),
  .dump_req(dump_req), .dump_id(dump_id), .timing(timing), .pixel_in(pixel_in),
  .default_video(default_video), .fetch_abort_q(fetch_abort_q), .cmd_start_q(cmd_start_q),
  .command_idle_flag_q(command_idle_flag_q), .display_status_word_q(display_status_word_q),
  .irq_mask_q(irq_mask_q), .dump_valid_q(dump_valid_q), .dump_data_q(dump_data_q),
  .test_mode_q(test_mode_q), .video_pixel_out_q(video_pixel_out_q),
  .video_oe_n_q(video_oe_n_q), .sync_oe_n_q(sync_oe_n_q));

// ===== vsa_display_test_tb_top.sv
// Self-checking bench for the display test block.
// Assumes package and checker are compiled first; inputs move at negedge.
module vsa_display_test_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk = 1'b0, sys_rst = 1'b1, rd_strap_n = 1'b1, wr_strap_n = 1'b1;
  logic memory_io_select = 1'b1, cmd_wr = 1'b0, cmd_done = 1'b0, dump_req = 1'b0;
  logic status_clr = 1'b0, mask_wr = 1'b0;
  logic [15:0] cmd_wdata = 16'h0000, mask_wdata = 16'h0000;
  logic [7:0]  dump_id = 8'h00, pixel_in = 8'h00, default_video = 8'h00, pix_seen;
  vsa_pkg::vsa_timing_t timing = 4'h0;
  logic fetch_abort_q, cmd_start_q, command_idle_flag_q, dump_valid_q, video_oe_n_q;
  logic hsync_out_q, vsync_out_q, retrace_gate_out_q, sync_oe_n_q;
  logic [15:0] display_command_register_q, display_status_word_q, irq_mask_q, dump_data_q;
  logic [5:0]  test_mode_q;
  logic [7:0]  video_pixel_out_q;
  logic [15:0] sig_m = 16'h0000;
  int          n_errors = 0, total_checks = 0, seed = 32'he056529f;
  // Free-running 250 MHz clock
  always #2 clk = ~clk;
  vsa_display_test u_dut (.clk, .sys_rst, .rd_strap_n, .wr_strap_n, .memory_io_select,
    .cmd_wr, .cmd_wdata, .cmd_done, .dump_req, .dump_id, .status_clr, .mask_wr, .mask_wdata,
    .timing, .pixel_in, .default_video, .fetch_abort_q, .cmd_start_q,
    .display_command_register_q, .command_idle_flag_q, .display_status_word_q, .irq_mask_q,
    .dump_valid_q, .dump_data_q, .test_mode_q, .video_pixel_out_q, .video_oe_n_q,
    .hsync_out_q, .vsync_out_q, .retrace_gate_out_q, .sync_oe_n_q);
  vsa_palette_model u_palette (.clk(clk), .pix_drv(video_pixel_out_q),
    .pix_oe_n(video_oe_n_q), .pix_seen(pix_seen));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize
  function automatic vsa_pkg::vsa_mode_t mode_of(input logic [2:0] c);
    case (c)
      vsa_pkg::STRAP_TEST:  return vsa_pkg::MODE_TEST;
      vsa_pkg::STRAP_HIGH:  return vsa_pkg::MODE_HIGH;
      vsa_pkg::STRAP_LOW:   return vsa_pkg::MODE_LOW;
      vsa_pkg::STRAP_FLOAT: return vsa_pkg::MODE_FLOAT;
      3'h6, 3'h7:           return vsa_pkg::MODE_NORMAL;
      default:              return vsa_pkg::MODE_RSVD;
    endcase
  endfunction : mode_of
  // Bit-serial reference of the byte fold, MSB first
  function automatic logic [15:0] fold(input logic [15:0] s, input logic [7:0] d);
    logic fb;
    for (int i = 7; i >= 0; i--) begin
      fb = s[15] ^ d[i];
      s = {s[14:0], 1'b0} ^ (fb ? vsa_pkg::SIG_POLY : 16'h0000);
    end
    return s;
  endfunction : fold
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic do_reset(input logic [2:0] code);
    timing = 4'h0;
    {rd_strap_n, wr_strap_n, memory_io_select} = code;
    sys_rst = 1'b1;
    cyc(8);
    chk("abort", 16'h0001, 16'(fetch_abort_q));
    sys_rst = 1'b0;
    cyc(4);
    chk("mode", 16'(mode_of(code)), 16'(test_mode_q));
    chk("mask", 16'hFFFF, irq_mask_q);
    chk("status", 16'h0001, display_status_word_q);
    chk("idle", 16'h0001, 16'(command_idle_flag_q));
  endtask : do_reset
  // Command write; start or refusal shows one cycle later
  task automatic send_cmd(input logic [15:0] w, input logic ok);
    cmd_wr = 1'b1;
    cmd_wdata = w;
    cyc(1);
    cmd_wr = 1'b0;
    chk("start", 16'(ok), 16'(cmd_start_q));
    chk("rsvd", 16'(!ok), 16'(display_status_word_q[1]));
    cmd_done = ok;
    cyc(2);
    cmd_done = 1'b0;
    chk("idle_back", 16'h0001, 16'(command_idle_flag_q));
  endtask : send_cmd
  task automatic dump_chk(input logic [7:0] id, input logic [15:0] exp);
    dump_req = 1'b1;
    dump_id = id;
    cyc(1);
    dump_req = 1'b0;
    chk("dump_valid", 16'h0001, 16'(dump_valid_q));
    chk("dump_data", exp, dump_data_q);
  endtask : dump_chk
  // Vsync pulse; the signature restarts
  task automatic vpulse();
    timing = 4'h5;
    cyc(3);
    timing = 4'h4;
    cyc(3);
    sig_m = 16'h0000;
  endtask : vpulse
  // Lines: 8 active, 4 blank, hsync on blank 2 and 3
  task automatic run_frame(input int lines, input logic tst);
    logic [7:0] exp;
    for (int l = 0; l < lines; l++) begin
      for (int c = 0; c < 12; c++) begin
        default_video = 8'($random(seed));
        pixel_in = 8'($random(seed));
        timing = {c < 8, c >= 8, c == 9 || c == 10, 1'b0};
        if (c < 8) begin
          sig_m = fold(sig_m, pixel_in);
          exp = pixel_in;
        end else if (tst) begin
          exp = timing.hsync ? sig_m[15:8] : sig_m[7:0];
        end else begin
          exp = default_video;
        end
        cyc(1);
        chk("pins", 16'(exp), 16'(pix_seen));
        chk("sync", 16'(timing[2:0]),
            16'({retrace_gate_out_q, hsync_out_q, vsync_out_q}));
      end
    end
    timing = 4'h4;
  endtask : run_frame
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    for (int c = 0; c < 8; c++) begin
      do_reset(3'(c));
    end
    do_reset(3'h7);
    chk("sync_float", 16'h0001, 16'(sync_oe_n_q));
    mask_wr = 1'b1;
    mask_wdata = 16'h00F0;
    cyc(1);
    mask_wr = 1'b0;
    cyc(1);
    chk("mask_wr", 16'h00F0, irq_mask_q);
    send_cmd(16'h4000, 1'b0);
    status_clr = 1'b1;
    cyc(1);
    status_clr = 1'b0;
    cyc(1);
    send_cmd(16'h0000, 1'b1);
    chk("sync_drive", 16'h0000, 16'(sync_oe_n_q));
    vpulse();
    run_frame(3, 1'b0);
    dump_chk(8'h3C, sig_m);
    dump_chk(8'h10, 16'h0000);
    vpulse();
    dump_chk(8'h3C, 16'h0000);
    do_reset(3'h2);
    send_cmd(16'h4000, 1'b1);
    vpulse();
    run_frame(2, 1'b1);
    dump_chk(8'h3C, sig_m);
    summarize();
  end
  // Hang guard ends in the same report
  initial begin
    #200000;
    n_errors++;
    summarize();
  end
endmodule : vsa_display_test_tb_top
